// ==== verilog/quad_serial_read_master_map.vh ====
// Constants for the quad serial read master
`ifndef QUAD_SERIAL_READ_MASTER_MAP_VH
`define QUAD_SERIAL_READ_MASTER_MAP_VH
`define PIN_MODE_3 2'h0
`define PIN_MODE_4 2'h1
`define PIN_MODE_6 2'h2
`define LANE_SINGLE 2'h0
`define LANE_DUAL 2'h1
`define LANE_QUAD 2'h2
`define SHIFT_WIDTH 128
`define MM_CMD_LEN_M1 7'h07
`define MM_ADDR_LEN_M1 7'h17
`define MM_DATA_LEN_M1 7'h1f
`define MM_WORDS_M1 12'h002
`define MM_STAGE_CMD 2'h0
`define MM_STAGE_ADDR 2'h1
`define LAG_PERIODS_M1 2'h1
`define DIV_ZERO_PERIOD 9'h002
`define DIV_ZERO_HIGH 9'h001
`define STORE_WORDS 4
`endif

// ==== verilog/rx_word_store.v ====
// Small store for the last received word, registered read
`timescale 1ns/10ps
`default_nettype none
`include "quad_serial_read_master_map.vh"
module rx_word_store (
  input wire clk,
  input wire we,
  input wire [127:0] wdata,
  input wire [1:0] raddr,
  output reg [31:0] rdata
);
  reg [31:0] mem [0:`STORE_WORDS-1];
  integer i;
  always @(posedge clk) begin
    if (we) begin
      for (i = 0; i < `STORE_WORDS; i = i + 1) begin
        mem[i] <= wdata[i*32 +: 32];
      end
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ==== verilog/quad_serial_read_master.v ====
// Master-only quad serial read port with memory-mapped read path
`timescale 1ns/10ps
`default_nettype none
`include "quad_serial_read_master_map.vh"
//
// Contract
// - Always master; drives clock and select
// - Reads on one, two or four lines
// - Mapped reads fetch data without software
// - Word length one to 128 bits
// - Frame holds one to 4096 words
// - Three, four or six pin configurations
// - Optional interrupt on word or frame
// - Select to data delay zero to three
// - Divider sets clock; even nonzero settings skew duty
// - Mode zero; clock idles low
// - Incoming data sampled on falling edge
// - Select leads first fall by delay+1
// - Select releases two periods after last fall
// - First bit one period early; change on falls
module quad_serial_read_master (
  input wire clk,
  input wire rst,
  input wire start,
  input wire write_not_read,
  input wire [6:0] word_len_m1,
  input wire [11:0] word_count_m1,
  input wire [127:0] tx_word,
  input wire [1:0] lane_mode,
  input wire [1:0] pin_mode,
  input wire [7:0] serial_clock_divide_setting,
  input wire [1:0] select_to_clock_delay_field,
  input wire clock_phase_select,
  input wire mm_req,
  input wire [23:0] mm_addr,
  input wire [7:0] mm_read_cmd,
  input wire word_irq_en,
  input wire frame_irq_en,
  input wire irq_clear,
  input wire [1:0] rx_sel,
  input wire [3:0] d_in,
  output reg sclk,
  output reg cs_n,
  output wire [3:0] d_out,
  output wire [3:0] d_oe,
  output wire busy,
  output reg word_done,
  output reg frame_done,
  output reg mm_ack,
  output reg [31:0] mm_rdata,
  output wire [31:0] rx_data,
  output reg word_flag,
  output reg frame_flag,
  output wire irq
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SETUP = 5'h02;
  localparam [4:0] ST_LEAD = 5'h04;
  localparam [4:0] ST_XFER = 5'h08;
  localparam [4:0] ST_LAG = 5'h10;

  function [8:0] sclk_period;
    input [7:0] d;
    begin
      sclk_period = (d == 8'h00) ? `DIV_ZERO_PERIOD : {1'b0, d} + 9'h001;
    end
  endfunction

  function [8:0] sclk_high;
    input [7:0] d;
    reg [8:0] p;
    begin
      p = {1'b0, d} + 9'h001;
      if (d == 8'h00) begin
        sclk_high = `DIV_ZERO_HIGH;
      end else if (d[0]) begin
        sclk_high = p >> 1;
      end else begin
        sclk_high = {1'b0, d} >> 1;
      end
    end
  endfunction

  function [2:0] eff_lanes;
    input [1:0] lm;
    input [1:0] pm;
    input wr;
    begin
      if (wr || pm != `PIN_MODE_6) begin
        eff_lanes = 3'h1;
      end else if (lm == `LANE_QUAD) begin
        eff_lanes = 3'h4;
      end else if (lm == `LANE_DUAL) begin
        eff_lanes = 3'h2;
      end else begin
        eff_lanes = 3'h1;
      end
    end
  endfunction

  function [127:0] shift_in;
    input [127:0] r;
    input [2:0] lanes;
    input [1:0] pm;
    input [3:0] din;
    begin
      if (lanes == 3'h4) begin
        shift_in = {r[123:0], din};
      end else if (lanes == 3'h2) begin
        shift_in = {r[125:0], din[1:0]};
      end else if (pm == `PIN_MODE_3) begin
        shift_in = {r[126:0], din[0]};
      end else begin
        shift_in = {r[126:0], din[1]};
      end
    end
  endfunction

  function [6:0] w_len_m1;
    input m;
    input [1:0] stg;
    input [6:0] sw;
    begin
      if (!m) begin
        w_len_m1 = sw;
      end else if (stg == `MM_STAGE_CMD) begin
        w_len_m1 = `MM_CMD_LEN_M1;
      end else if (stg == `MM_STAGE_ADDR) begin
        w_len_m1 = `MM_ADDR_LEN_M1;
      end else begin
        w_len_m1 = `MM_DATA_LEN_M1;
      end
    end
  endfunction

  function w_wr;
    input m;
    input [1:0] stg;
    input sw;
    begin
      w_wr = m ? (stg == `MM_STAGE_CMD || stg == `MM_STAGE_ADDR) : sw;
    end
  endfunction

  function [127:0] w_tx;
    input m;
    input [1:0] stg;
    input [127:0] sw;
    input [7:0] c;
    input [23:0] a;
    input [6:0] ln;
    reg [6:0] l;
    begin
      l = w_len_m1(m, stg, 7'h00);
      if (!m) begin
        w_tx = sw << (7'h7f - ln);
      end else if (stg == `MM_STAGE_CMD) begin
        w_tx = {c, 120'h0};
      end else if (stg == `MM_STAGE_ADDR) begin
        w_tx = {a, 104'h0};
      end else begin
        w_tx = {121'h0, l};
      end
    end
  endfunction

  reg [4:0] state;
  reg mm;
  reg [1:0] stage;
  reg [7:0] div_q;
  reg [1:0] dd_q;
  reg [1:0] lane_q;
  reg [1:0] pin_q;
  reg wr_q;
  reg [6:0] len_m1_q;
  reg [11:0] cnt_m1_q;
  reg [127:0] tx_q;
  reg [7:0] cmd_q;
  reg [23:0] addr_q;
  reg [8:0] div_cnt;
  reg [1:0] per_cnt;
  reg [7:0] bits_left;
  reg [11:0] words_left;
  reg [127:0] tx_sh;
  reg [127:0] rx_sh;
  reg store_we;

  wire [8:0] period = sclk_period(div_q);
  wire [8:0] low_time = period - sclk_high(div_q);
  wire period_end = (div_cnt == period - 9'h001);
  wire cur_wr = w_wr(mm, stage, wr_q);
  wire [2:0] cur_lanes = eff_lanes(lane_q, pin_q, cur_wr);
  wire [127:0] next_rx = shift_in(rx_sh, cur_lanes, pin_q, d_in);
  wire [1:0] next_stage = stage + 2'h1;
  wire last_chunk = (bits_left <= {5'h00, cur_lanes});
  wire active = (state == ST_LEAD) || (state == ST_XFER) || (state == ST_LAG);

  assign busy = (state != ST_IDLE);
  assign irq = word_flag | frame_flag;
  assign d_out = {3'h0, tx_sh[127]};
  // Data line 0 released during dual and quad reads
  assign d_oe = {3'h0, active && (cur_wr || (pin_q != `PIN_MODE_3 && cur_lanes == 3'h1))};

  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      mm <= 1'b0;
      stage <= 2'h0;
      div_q <= 8'h00;
      dd_q <= 2'h0;
      lane_q <= 2'h0;
      pin_q <= 2'h0;
      wr_q <= 1'b0;
      len_m1_q <= 7'h00;
      cnt_m1_q <= 12'h000;
      tx_q <= 128'h0;
      cmd_q <= 8'h00;
      addr_q <= 24'h000000;
      div_cnt <= 9'h000;
      per_cnt <= 2'h0;
      bits_left <= 8'h00;
      words_left <= 12'h000;
      tx_sh <= 128'h0;
      rx_sh <= 128'h0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      word_done <= 1'b0;
      frame_done <= 1'b0;
      mm_ack <= 1'b0;
      mm_rdata <= 32'h0;
      store_we <= 1'b0;
      word_flag <= 1'b0;
      frame_flag <= 1'b0;
    end else begin
      word_done <= 1'b0;
      frame_done <= 1'b0;
      mm_ack <= 1'b0;
      store_we <= 1'b0;
      if (word_done && word_irq_en) begin
        word_flag <= 1'b1;
      end else if (irq_clear) begin
        word_flag <= 1'b0;
      end
      if (frame_done && frame_irq_en) begin
        frame_flag <= 1'b1;
      end else if (irq_clear) begin
        frame_flag <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          sclk <= 1'b0;
          cs_n <= 1'b1;
          if (mm_req || start) begin
            mm <= mm_req;
            stage <= `MM_STAGE_CMD;
            div_q <= serial_clock_divide_setting;
            dd_q <= select_to_clock_delay_field;
            lane_q <= lane_mode;
            pin_q <= pin_mode;
            wr_q <= mm_req ? 1'b0 : write_not_read;
            len_m1_q <= word_len_m1;
            cnt_m1_q <= word_count_m1;
            tx_q <= tx_word;
            cmd_q <= mm_read_cmd;
            addr_q <= mm_addr;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cs_n <= 1'b0;
          div_cnt <= 9'h000;
          per_cnt <= 2'h0;
          words_left <= mm ? `MM_WORDS_M1 : cnt_m1_q;
          bits_left <= {1'b0, w_len_m1(mm, stage, len_m1_q)} + 8'h01;
          rx_sh <= 128'h0;
          if (dd_q == 2'h0) begin
            tx_sh <= w_tx(mm, stage, tx_q, cmd_q, addr_q, len_m1_q);
            state <= ST_XFER;
          end else begin
            tx_sh <= 128'h0;
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          div_cnt <= period_end ? 9'h000 : div_cnt + 9'h001;
          if (period_end) begin
            per_cnt <= per_cnt + 2'h1;
            if (per_cnt == dd_q - 2'h1) begin
              tx_sh <= w_tx(mm, stage, tx_q, cmd_q, addr_q, len_m1_q);
              state <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (period_end) begin
            div_cnt <= 9'h000;
            sclk <= 1'b0;
            rx_sh <= next_rx;
            if (!last_chunk) begin
              bits_left <= bits_left - {5'h00, cur_lanes};
              tx_sh <= {tx_sh[126:0], 1'b0};
            end else begin
              word_done <= 1'b1;
              store_we <= 1'b1;
              if (words_left != 12'h000) begin
                words_left <= words_left - 12'h001;
                stage <= next_stage;
                bits_left <= {1'b0, w_len_m1(mm, next_stage, len_m1_q)} + 8'h01;
                tx_sh <= w_tx(mm, next_stage, tx_q, cmd_q, addr_q, len_m1_q);
              end else begin
                per_cnt <= 2'h0;
                state <= ST_LAG;
                if (mm) begin
                  mm_rdata <= next_rx[31:0];
                end
              end
            end
          end else begin
            div_cnt <= div_cnt + 9'h001;
            if (div_cnt + 9'h001 == low_time) begin
              sclk <= 1'b1;
            end
          end
        end
        ST_LAG: begin
          div_cnt <= period_end ? 9'h000 : div_cnt + 9'h001;
          if (period_end) begin
            per_cnt <= per_cnt + 2'h1;
            if (per_cnt == `LAG_PERIODS_M1) begin
              cs_n <= 1'b1;
              frame_done <= 1'b1;
              mm_ack <= mm;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          cs_n <= 1'b1;
          sclk <= 1'b0;
        end
      endcase
    end
  end

  rx_word_store store (
    .clk(clk),
    .we(store_we),
    .wdata(rx_sh),
    .raddr(rx_sel),
    .rdata(rx_data)
  );
endmodule
`default_nettype wire

// ==== verification/qsrm_chk.sv ====
// Port checker for the quad serial read master
`timescale 1ns/10ps
`default_nettype none
module qsrm_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [7:0] serial_clock_divide_setting,
  input wire logic [1:0] select_to_clock_delay_field,
  input wire logic [3:0] d_out,
  input wire logic [3:0] d_oe,
  input wire logic word_done,
  input wire logic word_irq_en,
  input wire logic word_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic sclk_q, seen;
  logic [10:0] lead, since;
  logic [8:0] hi, per;
  assign per = serial_clock_divide_setting == 8'h00 ? 9'h002 : {1'b0, serial_clock_divide_setting} + 9'h001;
  // Lead, lag and high-time counters
  always @(posedge clk) begin
    sclk_q <= sclk;
    hi <= sclk ? hi + 9'h001 : 9'h000;
    since <= (sclk_q && !sclk) ? 11'h001 : since + 11'h001;
    seen <= !(rst || cs_n) && (seen || (sclk_q && !sclk));
    lead <= (rst || cs_n) ? 11'h000 : (seen ? lead : lead + 11'h001);
  end
  sequence s_fall;
    sclk_q && !sclk;
  endsequence
  chk_idle_clock: assert property (cs_n |-> !sclk) else $error("clock active while deselected");
  chk_reset_idle: assert property ($fell(rst) |-> cs_n && !sclk) else $error("not idle after reset");
  chk_take_select: assert property (start && !busy |-> ##[2:3] !cs_n) else $error("no select");
  chk_lead_time: assert property ((!seen && !cs_n) ##0 s_fall |->
    lead == ({9'h000, select_to_clock_delay_field} + 11'h001) * {2'b00, per}) else $error("bad lead");
  chk_lag_time: assert property ($rose(cs_n) |-> since == {1'b0, per, 1'b0}) else $error("bad lag");
  chk_high_time: assert property (s_fall |-> hi == (per >> 1)) else $error("bad high time");
  chk_data_edge: assert property (seen && d_oe[0] && $changed(d_out[0]) |-> $fell(sclk))
    else $error("data off edge");
  chk_word_flag: assert property (word_done && word_irq_en |=> word_flag) else $error("flag");
endmodule
`default_nettype wire

// ==== verification/flash_model.sv ====
// Behavioural serial flash answering reads
`timescale 1ns/10ps
`default_nettype none
module flash_model (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [1:0] lane_mode,
  input wire logic [1:0] pin_mode,
  input wire logic [5:0] skip,
  input wire logic [127:0] pat,
  output logic [3:0] d
);
  logic [127:0] sh;
  integer cnt;
  initial d = 4'h0;
  task put;
    begin
      d = ~d;
      if (lane_mode == 2'h2) d = sh[127:124];
      else if (lane_mode == 2'h1) d[1:0] = sh[127:126];
      else if (pin_mode == 2'h0) d[0] = sh[127];
      else d[1] = sh[127];
    end
  endtask
  always @(negedge cs_n) begin
    sh = pat;
    cnt = 0;
    put;
  end
  always @(negedge sclk) begin
    #1;
    if (!cs_n) begin
      cnt = cnt + 1;
      if (cnt > skip) sh = sh << (lane_mode == 2'h2 ? 4 : lane_mode == 2'h1 ? 2 : 1);
      put;
    end
  end
  always @(posedge cs_n) d = ~d;
endmodule
`default_nettype wire

// ==== verification/test_quad_serial_read_master.sv ====
// Self-checking bench for the quad serial read master
`timescale 1ns/10ps
`default_nettype none
module test_quad_serial_read_master;
  logic clk, rst, start, mm_req, wen, fen, irq_clear, sclk, cs_n, busy;
  logic word_done, frame_done, mm_ack, word_flag, frame_flag, irq;
  logic [1:0] lane_mode, pin_mode, dd;
  logic [6:0] len;
  logic [11:0] cnt;
  logic [7:0] div;
  logic [3:0] d_in, fd, d_out, d_oe;
  logic [5:0] skip;
  logic [127:0] pat;
  logic [31:0] mm_rdata, rx_data, cap;
  integer error_cnt, compares, seed, words, rc, i;
  assign d_in = (d_oe & d_out) | (~d_oe & fd);
  quad_serial_read_master i_dut (.clk(clk), .rst(rst), .start(start), .write_not_read(1'b0),
    .word_len_m1(len), .word_count_m1(cnt), .tx_word(128'h0), .lane_mode(lane_mode), .pin_mode(pin_mode),
    .serial_clock_divide_setting(div), .select_to_clock_delay_field(dd), .clock_phase_select(1'b0),
    .mm_req(mm_req), .mm_addr(pat[23:0]), .mm_read_cmd(pat[31:24]), .word_irq_en(wen), .frame_irq_en(fen),
    .irq_clear(irq_clear), .rx_sel(2'h0), .d_in(d_in), .sclk(sclk), .cs_n(cs_n), .d_out(d_out), .d_oe(d_oe),
    .busy(busy), .word_done(word_done), .frame_done(frame_done), .mm_ack(mm_ack), .mm_rdata(mm_rdata),
    .rx_data(rx_data), .word_flag(word_flag), .frame_flag(frame_flag), .irq(irq));
  flash_model i_flash (.cs_n(cs_n), .sclk(sclk), .lane_mode(lane_mode), .pin_mode(pin_mode), .skip(skip),
    .pat(pat), .d(fd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (word_done === 1'b1) words <= words + 1;
  always @(posedge sclk) begin
    if (rc < 32) cap = {cap[30:0], d_out[0]};
    rc = rc + 1;
  end
  always @(posedge cs_n) rc = 0;
  task check(input logic [127:0] seen, input logic [127:0] want, input string name);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", name, want, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("Compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  function logic [31:0] exp_word(input logic [127:0] p, input integer bits, input integer total);
    logic [127:0] e;
    logic [128:0] m;
    begin
      e = p >> (128 - total);
      m = (129'h1 << bits) - 129'h1;
      exp_word = e[31:0] & m[31:0];
    end
  endfunction
  task run(input logic [1:0] lm, input logic [1:0] pm, input logic mm, input logic [6:0] l, input logic [11:0] c);
    integer n, fpw, t;
    begin
      n = lm == 2'h2 ? 4 : lm == 2'h1 ? 2 : 1;
      fpw = (l + n) / n;
      @(posedge clk);
      lane_mode <= lm;
      pin_mode <= pm;
      len <= l;
      cnt <= c;
      skip <= mm ? 6'h20 : 6'h00;
      div <= 8'($random(seed) & 7);
      dd <= 2'($random(seed));
      wen <= 1'($random(seed));
      fen <= 1'($random(seed));
      pat <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      irq_clear <= 1'b1;
      words = 0;
      @(posedge clk);
      irq_clear <= 1'b0;
      start <= !mm;
      mm_req <= mm;
      @(posedge clk);
      start <= 1'b0;
      mm_req <= 1'b0;
      t = 0;
      while ((mm ? mm_ack : frame_done) !== 1'b1 && t < 40000) begin
        @(negedge clk);
        t = t + 1;
      end
      if (t >= 40000) begin
        error_cnt = error_cnt + 1;
        $display("ERROR done expected 1 seen timeout");
      end
      @(negedge clk);
      check(cs_n, 1'b1, "cs_n");
      if (mm) begin
        check(mm_rdata, pat[127:96], "mm_rdata");
        check(cap, pat[31:0], "command");
      end else begin
        check(words, c + 1, "words");
        if (fpw * n * (c + 1) <= 128) check(rx_data, exp_word(pat, fpw * n * (c + 1), fpw * n * (c + 1)), "rx");
        check({frame_flag, word_flag, irq}, {fen, wen, fen | wen}, "flags");
      end
    end
  endtask
  initial begin
    seed = 78;
    error_cnt = 0;
    compares = 0;
    rc = 0;
    cap = 32'h0;
    {rst, start, mm_req, wen, fen, irq_clear} = 6'h20;
    {lane_mode, pin_mode, dd, len, cnt, div, skip, pat} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 15; i = i + 1) run(2'(i % 3), 2'h2, 1'b0, 7'($random(seed) & 31), 12'($random(seed) & 3));
    run(2'h0, 2'h0, 1'b0, 7'h1f, 12'h001);
    run(2'h0, 2'h1, 1'b0, 7'h1f, 12'h001);
    run(2'h0, 2'h2, 1'b0, 7'h7f, 12'h000);
    run(2'h0, 2'h2, 1'b0, 7'h00, 12'hfff);
    for (i = 0; i < 3; i = i + 1) run(2'(i), 2'h2, 1'b1, 7'h00, 12'h000);
    give_verdict;
  end
  initial begin
    #900000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule
bind quad_serial_read_master qsrm_chk i_chk (.clk(clk), .rst(rst), .start(start), .busy(busy), .cs_n(cs_n),
  .sclk(sclk), .serial_clock_divide_setting(serial_clock_divide_setting),
  .select_to_clock_delay_field(select_to_clock_delay_field), .d_out(d_out), .d_oe(d_oe),
  .word_done(word_done), .word_irq_en(word_irq_en), .word_flag(word_flag));
`default_nettype wire
